// *** dv/other_lband_model.sv ***
/*
 * Behavioural model of another onboard L-band unit on the shared line.
 * Assumes one clock shared with the bench; the line is a wired-OR with a
 * pull-down, so a released line reads low.
 */
`timescale 1ns/100ps

module other_lband_model #(
    parameter int unsigned RECOV_CYC = 15
) (
    input wire logic clk,             // System clock
    input wire logic reset_n,         // Async reset, active low
    input wire logic own_supp,        // Device drive onto the line
    input wire logic tx_req,          // Pulse: start own transmission
    input wire logic [15:0] tx_len,   // Transmission length, cycles
    output logic line,                // Resolved shared line
    output logic blank                // Receiver blanked or recovering
);
    logic [15:0] tx_q;
    logic [15:0] rec_q;

    // Own drive lasts exactly the transmission; recovery follows release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_q <= 16'h0000;
            rec_q <= 16'h0000;
        end else begin
            if (tx_req) tx_q <= tx_len;
            else if (tx_q != 16'h0000) tx_q <= tx_q - 16'h0001;
            if (line) rec_q <= 16'(RECOV_CYC);
            else if (rec_q != 16'h0000) rec_q <= rec_q - 16'h0001;
        end
    end

    // Wired-OR of all drivers; nobody driving means pull-down low
    assign line = own_supp | (tx_q != 16'h0000);
    // Listener blanks while the line is high and for RECOV_CYC cycles after release
    assign blank = line | (rec_q != 16'h0000);
endmodule

// *** dv/tb_mutual_suppression_pulse_gen.sv ***
/*
 * Self-checking bench for the suppression pulse generator with shortened
 * counts. Assumes the partner model on the shared line and a 100 MHz clock.
 */
`timescale 1ns/100ps

module tb_mutual_suppression_pulse_gen;
    localparam logic [31:0] SHORT = 32'h0000_001C;
    localparam logic [31:0] LONG = 32'h0000_002A;
    localparam logic [31:0] MAX = 32'h0000_002B;
    localparam logic [31:0] PERIOD = 32'h0000_00C8;
    logic clk, reset_n, sched_enable, long_format, pwr_above_thr, tx_req;
    supp_pkg::tx_status_t tx_status;
    logic supp_out, line, blank;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int start_cyc = 0;
    int prev_cyc = 0;

    mutual_suppression_pulse_gen #(.SHORT_CYC(SHORT), .LONG_CYC(LONG), .MAX_CYC(MAX),
        .PERIOD_CYC(PERIOD)) dut (.clk(clk), .reset_n(reset_n),
        .sched_enable(sched_enable), .long_format(long_format),
        .pwr_above_thr(pwr_above_thr), .tx_status(tx_status), .supp_out(supp_out));
    other_lband_model #(.RECOV_CYC(15)) partner (.clk(clk), .reset_n(reset_n),
        .own_supp(supp_out), .tx_req(tx_req), .tx_len(16'h00C8), .line(line),
        .blank(blank));

    // Free-running clock and cycle count
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task test_done;
        $display("compares=%0d mismatches=%0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Sample just after the edge so its updates have landed
    task tick;
        @(posedge clk);
        #1;
    endtask

    task wait_hi(input int lim, input bit on_start);
        int i;
        for (i = 0; i < lim; i++) begin
            if ((on_start ? tx_status.start : supp_out) === 1'b1) break;
            tick();
        end
        if (i == lim) begin
            num_errors++;
            test_done();
        end
    endtask

    // One message: key length, cover, format, one-cycle tail
    task run_msg(input logic [31:0] len, input logic fmt);
        int n;
        n = 0;
        wait_hi(300, 1'b1);
        start_cyc = cyc;
        while (tx_status.active === 1'b1 && n < 1000) begin
            check(supp_out, 1'b1);
            n++;
            @(posedge clk);
            if (n == 2) long_format <= ~fmt;
            #1;
        end
        check(n, len);
        check(tx_status.long_fmt, fmt);
        check(supp_out, 1'b1);
        tick();
        check(supp_out, 1'b0);
    endtask

    task test_short;
        @(posedge clk);
        sched_enable <= 1'b1;
        long_format <= 1'b0;
        run_msg(SHORT, 1'b0);
        prev_cyc = start_cyc;
        $display("test_short done");
    endtask

    // Other unit holds the line across our next start; schedule must not move
    task test_long_other;
        @(posedge clk);
        tx_req <= 1'b1;
        long_format <= 1'b1;
        @(posedge clk);
        tx_req <= 1'b0;
        #1;
        check(line, 1'b1);
        check(blank, 1'b1);
        run_msg(LONG, 1'b1);
        check(start_cyc - prev_cyc, PERIOD);
        $display("test_long_other done");
    endtask

    // Power alone keys suppression; ceiling cuts it, drop re-arms
    task test_power;
        int n;
        n = 0;
        @(posedge clk);
        sched_enable <= 1'b0;
        repeat (3) tick();
        @(posedge clk);
        pwr_above_thr <= 1'b1;
        #1;
        wait_hi(4, 1'b0);
        check(supp_out, 1'b1);
        while (supp_out === 1'b1 && n < 100) begin
            n++;
            tick();
        end
        check(n, MAX);
        repeat (5) tick();
        check(supp_out, 1'b0);
        @(posedge clk);
        pwr_above_thr <= 1'b0;
        @(posedge clk);
        pwr_above_thr <= 1'b1;
        #1;
        wait_hi(4, 1'b0);
        check(supp_out, 1'b1);
        @(posedge clk);
        pwr_above_thr <= 1'b0;
        repeat (3) tick();
        check(supp_out, 1'b0);
        check(tx_status.active, 1'b0);
        $display("test_power done");
    endtask

    initial begin
        reset_n = 1'b0;
        sched_enable = 1'b0;
        long_format = 1'b0;
        pwr_above_thr = 1'b0;
        tx_req = 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        test_short();
        test_long_other();
        test_power();
        test_done();
    end
endmodule

// *** inc/supp_pkg.sv ***
/*
 * Shared constants and types for the transmit suppression block: message
 * durations, suppression ceiling, transmit scheduling period, state codes
 * and the transmit status bundle.
 * Assumes a single 100 MHz clock; all durations are derived from it here.
 */
package supp_pkg;

    // Clock rate, cycles per microsecond
    localparam int unsigned CLK_MHZ = 100;

    // Message and suppression durations in microseconds
    localparam int unsigned SHORT_MSG_US = 280;
    localparam int unsigned LONG_MSG_US = 420;
    localparam int unsigned MAX_SUPP_US = 430;
    // Mean spacing between transmissions, one per second
    localparam int unsigned SCHED_PERIOD_MS = 1000;

    // Cycle counts derived from the rate; exact multiples, so no rounding
    localparam int unsigned SHORT_MSG_CYC = SHORT_MSG_US * CLK_MHZ;
    localparam int unsigned LONG_MSG_CYC = LONG_MSG_US * CLK_MHZ;
    localparam int unsigned MAX_SUPP_CYC = MAX_SUPP_US * CLK_MHZ;
    localparam int unsigned SCHED_PERIOD_CYC = SCHED_PERIOD_MS * 1000 * CLK_MHZ;

    // Counter width, enough for the scheduling period
    localparam int unsigned CNT_W = 32;

    // Value of every counter after reset
    localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;

    // Suppression line state
    typedef enum logic [1:0] {
        SUPP_IDLE = 2'b00,
        SUPP_ON = 2'b01,
        SUPP_CAPPED = 2'b10
    } supp_state_t;

    // Transmit status toward the modulator
    typedef struct packed {
        logic start;     // One-cycle pulse at the first cycle of a message
        logic active;    // Transmit key, high for the whole message
        logic long_fmt;  // Format of the message in progress
    } tx_status_t;

    localparam tx_status_t TX_STATUS_RESET = 3'h0;

endpackage

// *** logic/down_timer.sv ***
/*
 * Loadable down-counter: loads a cycle count, then decrements to zero.
 * busy stays high for exactly the loaded number of cycles after the load.
 * Assumes load_val is nonzero when a full interval is wanted.
 */
`timescale 1ns/100ps

module down_timer #(
    parameter int unsigned W = 32
) (
    input wire logic clk,               // System clock
    input wire logic reset_n,           // Asynchronous reset, active low
    input wire logic load,              // Load load_val this cycle
    input wire logic [W-1:0] load_val,  // Interval in cycles
    output logic [W-1:0] count,         // Cycles still to run
    output logic busy                   // Count nonzero
);

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;

    // Load wins over decrement; stops at zero
    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = load_val;
        end else if (count_q != '0) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign count = count_q;
    assign busy = (count_q != '0);

endmodule

// *** logic/mutual_suppression_pulse_gen.sv ***
/*
 * Transmit scheduler and suppression line driver for an airborne L-band
 * broadcast transmitter. Starts a short or long message once per period,
 * keys the transmitter for the message length, and drives the shared
 * suppression line while transmitting or while radiated power is high, for at most MAX_CYC cycles each time it is raised.
 * Assumes: pwr_above_thr comes from an RF detector synchronous to clk;
 * the shared line is driven outward only and never read back here.
 */
`timescale 1ns/100ps

module mutual_suppression_pulse_gen #(
    parameter logic [31:0] SHORT_CYC = 32'(supp_pkg::SHORT_MSG_CYC),
    parameter logic [31:0] LONG_CYC = 32'(supp_pkg::LONG_MSG_CYC),
    parameter logic [31:0] MAX_CYC = 32'(supp_pkg::MAX_SUPP_CYC),
    parameter logic [31:0] PERIOD_CYC = 32'(supp_pkg::SCHED_PERIOD_CYC)
) (
    input wire logic clk,                       // System clock, 100 MHz
    input wire logic reset_n,                   // Asynchronous reset, active low
    input wire logic sched_enable,              // Allow periodic transmissions
    input wire logic long_format,               // Next message is long format
    input wire logic pwr_above_thr,             // Radiated power at/above threshold
    output supp_pkg::tx_status_t tx_status,     // Transmit key and status
    output logic supp_out                       // Drive to shared suppression line
);

    localparam int unsigned W = supp_pkg::CNT_W;

    logic [W-1:0] sched_cnt;
    logic sched_busy;
    logic [W-1:0] tx_cnt;
    logic tx_busy;
    logic [W-1:0] cap_cnt;
    logic cap_load;
    logic start;
    logic supp_req;

    supp_pkg::tx_status_t tx_q;
    supp_pkg::tx_status_t tx_d;
    supp_pkg::supp_state_t state_q;
    supp_pkg::supp_state_t state_d;
    logic supp_q;
    logic supp_d;

    // Start a message when the period has run out; no input from the
    // shared line exists, so other systems can never delay it
    assign start = sched_enable && !sched_busy && !tx_busy;

    // Period timer, reloaded at each start; loaded one short because the
    // start cycle itself is part of the period, so starts are PERIOD_CYC apart.
    // PERIOD_CYC must be at least 2
    down_timer #(
        .W(W)
    ) u_sched_timer (
        .clk(clk),
        .reset_n(reset_n),
        .load(start),
        .load_val(PERIOD_CYC - 32'h0000_0001),
        .count(sched_cnt),
        .busy(sched_busy)
    );

    // Message length timer, length chosen by format at start
    down_timer #(
        .W(W)
    ) u_msg_timer (
        .clk(clk),
        .reset_n(reset_n),
        .load(start),
        .load_val(long_format ? LONG_CYC : SHORT_CYC),
        .count(tx_cnt),
        .busy(tx_busy)
    );

    // Transmit key: high from the start edge for exactly the loaded count
    always_comb begin
        tx_d = tx_q;
        tx_d.start = start;
        tx_d.active = start || (tx_cnt > 32'h0000_0001);
        if (start) begin
            tx_d.long_fmt = long_format;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_q <= supp_pkg::TX_STATUS_RESET;
        end else begin
            tx_q <= tx_d;
        end
    end

    assign tx_status = tx_q;

    // Request includes start so the line rises with the transmit key;
    // power detector keeps it up over ramp tails outside the key
    assign supp_req = start || tx_busy || pwr_above_thr;

    // Ceiling timer armed each time the line is raised
    assign cap_load = (state_q == supp_pkg::SUPP_IDLE) && supp_req;

    down_timer #(
        .W(W)
    ) u_cap_timer (
        .clk(clk),
        .reset_n(reset_n),
        .load(cap_load),
        .load_val(MAX_CYC),
        .count(cap_cnt),
        .busy()
    );

    // Suppression state: capped state holds the line low until the
    // request drops, trading coverage of a stuck detector for bus safety
    always_comb begin
        state_d = state_q;
        case (state_q)
            supp_pkg::SUPP_IDLE: begin
                if (supp_req) begin
                    state_d = supp_pkg::SUPP_ON;
                end
            end
            supp_pkg::SUPP_ON: begin
                if (!supp_req) begin
                    state_d = supp_pkg::SUPP_IDLE;
                end else if (cap_cnt == 32'h0000_0001) begin
                    state_d = supp_pkg::SUPP_CAPPED;
                end
            end
            supp_pkg::SUPP_CAPPED: begin
                if (!supp_req) begin
                    state_d = supp_pkg::SUPP_IDLE;
                end
            end
            default: begin
                state_d = supp_pkg::SUPP_IDLE;
            end
        endcase
        supp_d = (state_d == supp_pkg::SUPP_ON);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= supp_pkg::SUPP_IDLE;
            supp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            supp_q <= supp_d;
        end
    end

    assign supp_out = supp_q;

    // Helper counters watched only by the checks below
    logic [W-1:0] tx_len_q;
    logic [W-1:0] tx_len_d;
    logic [W-1:0] supp_len_q;
    logic [W-1:0] supp_len_d;
    logic [W-1:0] gap_q;
    logic [W-1:0] gap_d;
    logic seen_q;
    logic seen_d;

    // Run lengths of key and line, and spacing between starts
    always_comb begin
        tx_len_d = tx_d.active ? tx_len_q + 1'b1 : supp_pkg::CNT_RESET;
        supp_len_d = supp_d ? supp_len_q + 1'b1 : supp_pkg::CNT_RESET;
        gap_d = gap_q;
        if (start) begin
            // Start cycle counts as one, so gap equals the spacing at next start
            gap_d = 32'h0000_0001;
        end else if (gap_q != 32'hFFFF_FFFF) begin
            gap_d = gap_q + 1'b1;
        end
        seen_d = seen_q || start;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_len_q <= supp_pkg::CNT_RESET;
            supp_len_q <= supp_pkg::CNT_RESET;
            gap_q <= supp_pkg::CNT_RESET;
            seen_q <= 1'b0;
        end else begin
            tx_len_q <= tx_len_d;
            supp_len_q <= supp_len_d;
            gap_q <= gap_d;
            seen_q <= seen_d;
        end
    end

    default clocking chk_clk @(posedge clk);
    endclocking

    default disable iff (!reset_n);

    // A message begins: key and start pulse one edge after the decision
    sequence tx_begin_s;
        ##1 (tx_q.active && tx_q.start && supp_q);
    endsequence

    // Release after the ceiling, held low while request persists
    sequence capped_low_s;
        ##1 (!supp_q && state_q == supp_pkg::SUPP_CAPPED);
    endsequence

    supp_covers_tx_a: assert property (
        tx_q.active && state_q != supp_pkg::SUPP_CAPPED |-> supp_q)
        else $error("suppression low during own transmission");

    sched_no_inhibit_a: assert property (
        sched_enable && !sched_busy && !tx_busy |-> tx_begin_s)
        else $error("due transmission did not start");

    short_length_a: assert property (
        $fell(tx_q.active) && !$past(tx_q.long_fmt) |-> $past(tx_len_q) == SHORT_CYC)
        else $error("short message length wrong");

    long_length_a: assert property (
        $fell(tx_q.active) && $past(tx_q.long_fmt) |-> $past(tx_len_q) == LONG_CYC)
        else $error("long message length wrong");

    power_gates_supp_a: assert property (
        pwr_above_thr && state_q != supp_pkg::SUPP_CAPPED && cap_cnt != 32'h0000_0001
        |=> supp_q)
        else $error("suppression low while power above threshold");

    max_hold_a: assert property (
        supp_q |-> supp_len_q <= MAX_CYC)
        else $error("suppression held beyond ceiling");

    start_rate_a: assert property (
        start && seen_q |-> gap_q >= PERIOD_CYC)
        else $error("transmissions closer than one period");

    cap_release_a: assert property (
        state_q == supp_pkg::SUPP_ON && cap_cnt == 32'h0000_0001 && supp_req
        |-> capped_low_s)
        else $error("ceiling did not force release");

endmodule
